// [rtl/eau_ext_access_unit.v]
`timescale 1ns/10ps
`default_nettype none
`include "eau_regs.vh"

module eau_ext_access_unit #(
    parameter NWIN = 4
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // access requests from cpu side
    input wire req_valid_i,
    input wire req_write_i,
    input wire [23:0] req_addr_i,
    input wire [15:0] req_wdata_i,
    output wire req_ready_o,
    output reg rsp_valid_o,
    output reg rsp_err_o,
    output reg [15:0] rsp_rdata_o,
    // configuration
    input wire cfg_single_chip_i,
    input wire [2:0] cfg_seg_lines_i,
    input wire cfg_ready_high_i,
    input wire [NWIN-1:0] win_en_i,
    input wire [NWIN*`EAU_WIN_BASE_W-1:0] window_range_base_i,
    input wire [NWIN*`EAU_WIN_SIZE_W-1:0] window_range_size_i,
    input wire [NWIN*`EAU_TCFG_W-1:0] window_timing_cfg_i,
    input wire [NWIN*`EAU_FCFG_W-1:0] window_function_cfg_i,
    input wire [`EAU_TCFG_W-1:0] default_timing_cfg_i,
    input wire [`EAU_FCFG_W-1:0] default_function_cfg_i,
    input wire cfg_arb_enable_i,
    input wire cfg_arb_slave_i,
    // status
    output wire [2:0] stat_window_o,
    output wire stat_bus_owned_o,
    // external bus pins
    output wire bus_reference_clock_out_o,
    output wire [15:0] demux_address_port_o,
    output wire demux_address_port_oe_o,
    output wire [15:0] shared_addr_data_port_o,
    output wire [1:0] shared_addr_data_port_oe_o,
    input wire [15:0] shared_addr_data_port_i,
    output wire [7:0] segment_addr_o,
    output wire [NWIN:0] cs_n_o,
    output wire ale_o,
    output wire rd_n_o,
    output wire wr_n_o,
    output wire ctrl_oe_o,
    input wire ready_i,
    // arbitration pins
    input wire arb_hold_n_i,
    input wire arb_grant_pin_n_i,
    output wire arb_grant_pin_n_o,
    output wire arb_grant_pin_oe_o,
    output wire arb_next_request_out_n_o,
    output wire arb_next_request_out_oe_o,
    // on-chip module bus
    output wire onchip_module_bus_sel_o,
    output wire onchip_module_bus_rd_o,
    output wire onchip_module_bus_wr_o,
    output wire [23:0] onchip_module_bus_addr_o,
    output wire [15:0] onchip_module_bus_wdata_o,
    input wire [15:0] onchip_module_bus_rdata_i,
    input wire onchip_module_bus_rdy_i
);

    //------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------
    reg [1:0] ready_ff;
    reg [1:0] hold_ff;
    reg [1:0] grant_in_ff;
    reg [15:0] din1_ff;
    reg [15:0] din2_ff;

    // two stages before any logic
    always @(posedge clk_i) begin
        if (rst_i) begin
            ready_ff <= 2'h0;
            hold_ff <= 2'h3;
            grant_in_ff <= 2'h3;
            din1_ff <= 16'h0000;
            din2_ff <= 16'h0000;
        end else begin
            ready_ff <= {ready_ff[0], ready_i};
            hold_ff <= {hold_ff[0], arb_hold_n_i};
            grant_in_ff <= {grant_in_ff[0], arb_grant_pin_n_i};
            din1_ff <= shared_addr_data_port_i;
            din2_ff <= din1_ff;
        end
    end

    //------------------------------------------------------------
    // reference clock divider
    //------------------------------------------------------------
    reg [3:0] div_ff;
    reg refclk_ff;
    wire tick;

    assign tick = (div_ff == `EAU_REF_HALF - 4'h1) && !refclk_ff;

    always @(posedge clk_i) begin
        if (rst_i) begin
            div_ff <= 4'h0;
            refclk_ff <= 1'b0;
        end else if (div_ff == `EAU_REF_HALF - 4'h1) begin
            div_ff <= 4'h0;
            refclk_ff <= !refclk_ff;
        end else begin
            div_ff <= div_ff + 4'h1;
        end
    end

    assign bus_reference_clock_out_o = refclk_ff;

    //------------------------------------------------------------
    // window selection
    //------------------------------------------------------------
    reg [2:0] hit;
    reg [11:0] msk;
    integer i;

    always @* begin
        hit = 3'h0;
        msk = 12'h000;
        for (i = 0; i < NWIN; i = i + 1) begin
            msk = ~((12'h001 << window_range_size_i[i*`EAU_WIN_SIZE_W +: `EAU_WIN_SIZE_W]) - 12'h001);
            if (win_en_i[i] && (((req_addr_i[23:12] ^ window_range_base_i[i*`EAU_WIN_BASE_W +: `EAU_WIN_BASE_W])
                & msk) == 12'h000)) begin
                hit = i[2:0] + 3'h1;
            end
        end
    end

    wire [`EAU_TCFG_W-1:0] sel_tcfg;
    wire [`EAU_FCFG_W-1:0] sel_fcfg;
    wire onchip_hit;

    // settings of hit window or default
    assign sel_tcfg = (hit == 3'h0) ? default_timing_cfg_i :
        window_timing_cfg_i[(hit - 3'h1)*`EAU_TCFG_W +: `EAU_TCFG_W];
    assign sel_fcfg = (hit == 3'h0) ? default_function_cfg_i :
        window_function_cfg_i[(hit - 3'h1)*`EAU_FCFG_W +: `EAU_FCFG_W];
    assign onchip_hit = req_addr_i[23:11] == `EAU_ONCHIP_TAG;

    //------------------------------------------------------------
    // access engine
    //------------------------------------------------------------
    reg [2:0] st_ff;
    reg [23:0] addr_ff;
    reg [15:0] wdata_ff;
    reg write_ff;
    reg onchip_ff;
    reg [1:0] mode_ff;
    reg [3:0] wait_ff;
    reg rdyen_ff;
    reg [2:0] win_ff;
    reg csen_ff;
    wire hold_act;
    wire grant_in_act;
    wire slave;
    wire own;
    wire rdy_act;
    wire ext_req;
    wire mux;
    wire bus8;

    assign slave = cfg_arb_enable_i && cfg_arb_slave_i;
    // hold only seen when arbitration enabled
    assign hold_act = cfg_arb_enable_i && !cfg_arb_slave_i && !hold_ff[1];
    assign grant_in_act = !grant_in_ff[1];
    // slave owns bus only while granted
    assign own = slave ? grant_in_act : (st_ff != `EAU_ST_HOLD);
    assign ext_req = req_valid_i && !onchip_hit;
    assign rdy_act = onchip_ff ? onchip_module_bus_rdy_i : (ready_ff[1] == cfg_ready_high_i);
    assign mux = (mode_ff == `EAU_MODE_MUX16) || (mode_ff == `EAU_MODE_MUX8);
    assign bus8 = (mode_ff == `EAU_MODE_MUX8) || (mode_ff == `EAU_MODE_DEMUX8);

    // accept at an idle tick, external only with the bus owned or in single-chip mode
    assign req_ready_o = (st_ff == `EAU_ST_IDLE) && tick && !hold_act &&
        (onchip_hit || cfg_single_chip_i || own);

    // main sequencer, advanced on reference clock ticks
    always @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= `EAU_ST_IDLE;
            addr_ff <= 24'h000000;
            wdata_ff <= 16'h0000;
            write_ff <= 1'b0;
            onchip_ff <= 1'b0;
            mode_ff <= `EAU_MODE_DEMUX16;
            wait_ff <= 4'h0;
            rdyen_ff <= 1'b0;
            win_ff <= 3'h0;
            csen_ff <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_err_o <= 1'b0;
            rsp_rdata_o <= 16'h0000;
        end else begin
            rsp_valid_o <= 1'b0;
            rsp_err_o <= 1'b0;
            case (st_ff)
                `EAU_ST_IDLE: begin
                    if (tick && hold_act) begin
                        // float and grant after access ends
                        st_ff <= `EAU_ST_HOLD;
                    end else if (req_valid_i && req_ready_o) begin
                        if (cfg_single_chip_i && !onchip_hit) begin
                            rsp_valid_o <= 1'b1;
                            rsp_err_o <= 1'b1;
                            rsp_rdata_o <= 16'h0000;
                        end else begin
                            st_ff <= `EAU_ST_ADDR;
                            addr_ff <= req_addr_i;
                            wdata_ff <= req_wdata_i;
                            write_ff <= req_write_i;
                            onchip_ff <= onchip_hit;
                            mode_ff <= sel_fcfg[`EAU_FCFG_MODE_LSB +: 2];
                            csen_ff <= sel_fcfg[`EAU_FCFG_CSEN];
                            wait_ff <= sel_tcfg[`EAU_TCFG_WAIT_LSB +: `EAU_TCFG_WAIT_W];
                            rdyen_ff <= sel_tcfg[`EAU_TCFG_RDYEN];
                            win_ff <= hit;
                        end
                    end
                end
                `EAU_ST_ADDR: begin
                    if (tick) begin
                        st_ff <= `EAU_ST_DATA;
                    end
                end
                `EAU_ST_DATA: begin
                    if (tick) begin
                        if (wait_ff != 4'h0) begin
                            wait_ff <= wait_ff - 4'h1;
                        end else if (!rdyen_ff || rdy_act) begin
                            st_ff <= `EAU_ST_IDLE;
                            rsp_valid_o <= 1'b1;
                            if (onchip_ff) begin
                                rsp_rdata_o <= onchip_module_bus_rdata_i;
                            end else if (bus8) begin
                                // byte modes use the low lane
                                rsp_rdata_o <= {8'h00, din2_ff[7:0]};
                            end else begin
                                rsp_rdata_o <= din2_ff;
                            end
                        end
                    end
                end
                `EAU_ST_HOLD: begin
                    if (tick && !hold_act) begin
                        st_ff <= `EAU_ST_IDLE;
                    end
                end
                default: begin
                    st_ff <= `EAU_ST_IDLE;
                end
            endcase
        end
    end

    //------------------------------------------------------------
    // external pin drive
    //------------------------------------------------------------
    wire ext_act;
    wire in_addr;
    wire in_data;
    wire [8:0] seg_msk;

    assign ext_act = !onchip_ff && ((st_ff == `EAU_ST_ADDR) || (st_ff == `EAU_ST_DATA));
    assign in_addr = ext_act && (st_ff == `EAU_ST_ADDR);
    assign in_data = ext_act && (st_ff == `EAU_ST_DATA);

    assign demux_address_port_o = addr_ff[15:0];
    assign demux_address_port_oe_o = own && !mux;
    // address phase then data on shared port
    assign shared_addr_data_port_o = (mux && in_addr) ? addr_ff[15:0] : wdata_ff;
    assign shared_addr_data_port_oe_o = !own ? 2'h0 : (mux && in_addr) ? 2'h3 :
        (in_data && write_ff) ? (bus8 ? 2'h1 : 2'h3) : 2'h0;
    assign seg_msk = (9'h001 << cfg_seg_lines_i) - 9'h001;
    assign segment_addr_o = addr_ff[23:16] & seg_msk[7:0];

    genvar g;
    generate
        for (g = 0; g <= NWIN; g = g + 1) begin : g_cs
            assign cs_n_o[g] = !(ext_act && csen_ff && (win_ff == g));
        end
    endgenerate

    assign ale_o = in_addr;
    assign rd_n_o = !(in_data && !write_ff);
    assign wr_n_o = !(in_data && write_ff);
    // control floats while another master holds
    assign ctrl_oe_o = own;

    //------------------------------------------------------------
    // arbitration pins
    //------------------------------------------------------------
    // pins taken only when enabled
    // grant pin output in master, input in slave
    assign arb_grant_pin_oe_o = cfg_arb_enable_i && !cfg_arb_slave_i;
    assign arb_grant_pin_n_o = !(st_ff == `EAU_ST_HOLD);
    assign arb_next_request_out_oe_o = cfg_arb_enable_i;
    // ask for the bus when an external access waits without it
    assign arb_next_request_out_n_o = !(ext_req && !cfg_single_chip_i && !own);

    //------------------------------------------------------------
    // on-chip module bus and status
    //------------------------------------------------------------
    // same sequence, internal strobes
    assign onchip_module_bus_sel_o = onchip_ff && ((st_ff == `EAU_ST_ADDR) || (st_ff == `EAU_ST_DATA));
    assign onchip_module_bus_rd_o = onchip_ff && (st_ff == `EAU_ST_DATA) && !write_ff;
    assign onchip_module_bus_wr_o = onchip_ff && (st_ff == `EAU_ST_DATA) && write_ff;
    assign onchip_module_bus_addr_o = addr_ff;
    assign onchip_module_bus_wdata_o = wdata_ff;

    assign stat_window_o = win_ff;
    assign stat_bus_owned_o = own;

endmodule

`default_nettype wire

// [rtl/eau_regs.vh]
//------------------------------------------------------------
// external access unit constants
//------------------------------------------------------------
// Overview of operation
// - single-chip or one of four bus modes
// - demux: address port, 16/8-bit data lanes
// - mux: address then data on shared port
// - segment lines output, count selectable
// - five active-low chip selects
// - ready extends access, polarity selectable
// - arbitration pins controlled only once enabled
// - master default, grant pin input as slave
// - per-window timing and function settings
// - four windows, higher number wins
// - unmatched accesses use default settings
// - assert chip select of selected window
// - bus mode switches per access window
// - bus steps on reference clock rising edge
// - on-chip module bus uses same engine
`ifndef EAU_REGS_VH
`define EAU_REGS_VH

// bus modes in function config
`define EAU_MODE_DEMUX16 2'h0
`define EAU_MODE_MUX16 2'h1
`define EAU_MODE_MUX8 2'h2
`define EAU_MODE_DEMUX8 2'h3

// timing config fields
`define EAU_TCFG_W 5
`define EAU_TCFG_WAIT_LSB 0
`define EAU_TCFG_WAIT_W 4
`define EAU_TCFG_RDYEN 4

// function config fields
`define EAU_FCFG_W 3
`define EAU_FCFG_MODE_LSB 0
`define EAU_FCFG_CSEN 2

// window range fields
`define EAU_WIN_BASE_W 12
`define EAU_WIN_SIZE_W 4

// on-chip module bus range, address bits 23:11
`define EAU_ONCHIP_TAG 13'h0400

// engine states
`define EAU_ST_IDLE 3'h0
`define EAU_ST_ADDR 3'h1
`define EAU_ST_DATA 3'h2
`define EAU_ST_HOLD 3'h3

// reference clock half period in clk cycles
`define EAU_REF_HALF 4'h2

`endif

// [test/eau_ext_access_unit_props.sv]
`timescale 1ns/10ps
`default_nettype none
`include "eau_regs.vh"
module eau_ext_access_unit_props #(
    parameter NWIN = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // request side
    input wire logic req_valid_i,
    input wire logic [23:0] req_addr_i,
    input wire logic req_ready_o,
    input wire logic rsp_valid_o,
    input wire logic rsp_err_o,
    input wire logic cfg_single_chip_i,
    input wire logic cfg_arb_enable_i,
    input wire logic cfg_arb_slave_i,
    // bus pins
    input wire logic bus_reference_clock_out_o,
    input wire logic [NWIN:0] cs_n_o,
    input wire logic ale_o,
    input wire logic rd_n_o,
    input wire logic wr_n_o,
    input wire logic ctrl_oe_o,
    input wire logic [1:0] shared_addr_data_port_oe_o,
    input wire logic arb_grant_pin_n_o,
    input wire logic arb_grant_pin_oe_o,
    input wire logic onchip_module_bus_sel_o
);
    // ------------------
    // pin checks
    // ------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire taken = req_valid_i && req_ready_o;
    // external access while single-chip, on-chip range excluded
    wire refused = cfg_single_chip_i && (req_addr_i[23:11] != `EAU_ONCHIP_TAG);

    err_with_valid_a: assert property (rsp_err_o |-> rsp_valid_o)
        else $error("error flag alone");
    single_refuse_a: assert property (taken && refused |=> rsp_valid_o && rsp_err_o)
        else $error("no refusal");
    min_latency_a: assert property (taken && !refused |=> !rsp_valid_o [*8] ##[1:300] rsp_valid_o)
        else $error("bad access length");
    tick_take_a: assert property (req_ready_o |=> $rose(bus_reference_clock_out_o))
        else $error("take off tick");
    one_select_a: assert property ($onehot0(~cs_n_o))
        else $error("two selects");
    ale_phase_a: assert property ($rose(ale_o) |->
        (ale_o && rd_n_o && wr_n_o) [*4] ##1 (!ale_o && rd_n_o != wr_n_o))
        else $error("bad address phase");
    hold_float_a: assert property (!arb_grant_pin_n_o && arb_grant_pin_oe_o |->
        !ctrl_oe_o && shared_addr_data_port_oe_o == 2'h0 && &cs_n_o)
        else $error("bus driven in hold");
    arb_off_a: assert property (!cfg_arb_enable_i [*2] |-> !arb_grant_pin_oe_o)
        else $error("grant pin driven");
    slave_input_a: assert property (cfg_arb_slave_i [*2] |-> !arb_grant_pin_oe_o)
        else $error("slave drives grant");
    onchip_quiet_a: assert property (onchip_module_bus_sel_o |-> &cs_n_o && !ale_o && rd_n_o && wr_n_o)
        else $error("pins active on internal access");
    cover property (taken && cfg_single_chip_i);
    cover property ($fell(arb_grant_pin_n_o));
    cover property ($rose(ale_o));
    cover property ($rose(onchip_module_bus_sel_o));
endmodule
bind eau_ext_access_unit eau_ext_access_unit_props #(.NWIN(NWIN)) u_props (
    .clk_i, .rst_i, .req_valid_i, .req_addr_i, .req_ready_o, .rsp_valid_o, .rsp_err_o, .cfg_single_chip_i,
    .cfg_arb_enable_i, .cfg_arb_slave_i, .bus_reference_clock_out_o, .cs_n_o, .ale_o, .rd_n_o,
    .wr_n_o, .ctrl_oe_o, .shared_addr_data_port_oe_o, .arb_grant_pin_n_o, .arb_grant_pin_oe_o,
    .onchip_module_bus_sel_o
);
`default_nettype wire

// [test/eau_ext_mem.sv]
`timescale 1ns/10ps
`default_nettype none
module eau_ext_mem (
    // controller pins
    input wire logic clk_i,
    input wire logic ale_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic dmx_oe_i,
    input wire logic [15:0] dmx_i,
    input wire logic [1:0] sh_oe_i,
    input wire logic [15:0] sh_i,
    // behaviour knobs
    input wire logic [3:0] slow_i,
    input wire logic pol_i,
    // answers
    output logic [15:0] data_o,
    output logic rdy_o
);
    // ------------------
    // memory model
    // ------------------
    logic [15:0] mem_ff [0:15];
    logic [3:0] adr_ff, cnt_ff;
    logic [15:0] last_ff = 16'h0;
    always @(posedge clk_i) begin
        if (ale_i)
            adr_ff <= dmx_oe_i ? dmx_i[4:1] : sh_i[4:1];
        if (!wr_n_i && sh_oe_i[0])
            mem_ff[adr_ff] <= {sh_oe_i[1] ? sh_i[15:8] : 8'h00, sh_i[7:0]};
        cnt_ff <= (rd_n_i && wr_n_i) ? 4'h0 : cnt_ff + {3'h0, cnt_ff != 4'hf};
        if (!rd_n_i)
            last_ff <= data_o;
    end
    assign rdy_o = (cnt_ff >= slow_i) ? pol_i : !pol_i;
    // released lines show inverse of last word
    assign data_o = !rd_n_i ? mem_ff[adr_ff] : ~last_ff;
endmodule
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
    // ------------------
    // signals
    // ------------------
    logic clk_i = 0, rst_i = 1, req_valid_i = 0, req_write_i = 0, err;
    logic [23:0] req_addr_i = 0;
    logic [15:0] req_wdata_i = 0, d;
    logic cfg_single_chip_i = 0, cfg_ready_high_i = 0, cfg_arb_enable_i = 0, cfg_arb_slave_i = 0;
    logic arb_hold_n_i = 1, gnt_n = 1;
    logic [2:0] cfg_seg_lines_i = 3'h2;
    logic [3:0] win_en = 4'hf, slow = 4'h0;
    logic [4:0] tcfg = 5'h00, cs_seen;
    logic [7:0] seg_seen;
    logic [23:0] oadr_seen;
    logic [3:0] ocnt = 4'h0;
    int lat, n_errors = 0, checked = 0;
    wire req_ready_o, rsp_valid_o, rsp_err_o, dmx_oe, ale_o, rd_n_o, wr_n_o, ctrl_oe_o, rdy;
    wire arb_grant_pin_n_o, arb_grant_pin_oe_o, bus_req_n, bus_req_oe, owned, onchip_rd;
    wire [23:0] onchip_adr;
    wire [1:0] sh_oe;
    wire [2:0] stat_window_o;
    wire [4:0] cs_n_o;
    wire [7:0] segment_addr_o;
    wire [15:0] rsp_rdata_o, dmx, sh_o, mdat;
    wire [15:0] sh_in = {sh_oe[1] ? sh_o[15:8] : mdat[15:8], sh_oe[0] ? sh_o[7:0] : mdat[7:0]};
    logic [23:0] adr [5] = '{24'h001002, 24'h010004, 24'h011006, 24'h0a0008, 24'h0a100a};
    logic [2:0] win [5] = '{3'h0, 3'h2, 3'h1, 3'h4, 3'h3};
    logic [4:0] csx [5] = '{5'h1e, 5'h1b, 5'h1d, 5'h0f, 5'h1f};
    logic w8 [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

    always #5 clk_i = ~clk_i;

    eau_ext_access_unit u_dut (
        .clk_i, .rst_i, .req_valid_i, .req_write_i, .req_addr_i, .req_wdata_i, .req_ready_o,
        .rsp_valid_o, .rsp_err_o, .rsp_rdata_o, .cfg_single_chip_i, .cfg_seg_lines_i, .cfg_ready_high_i,
        .win_en_i(win_en), .window_range_base_i({12'h0a0, 12'h0a0, 12'h010, 12'h010}),
        .window_range_size_i(16'h0104), .window_timing_cfg_i({4{tcfg}}),
        .window_function_cfg_i({3'h6, 3'h1, 3'h5, 3'h7}), .default_timing_cfg_i(tcfg),
        .default_function_cfg_i(3'h4), .cfg_arb_enable_i, .cfg_arb_slave_i, .stat_window_o,
        .stat_bus_owned_o(owned), .bus_reference_clock_out_o(), .demux_address_port_o(dmx),
        .demux_address_port_oe_o(dmx_oe), .shared_addr_data_port_o(sh_o), .shared_addr_data_port_oe_o(sh_oe),
        .shared_addr_data_port_i(sh_in), .segment_addr_o, .cs_n_o, .ale_o, .rd_n_o, .wr_n_o, .ctrl_oe_o,
        .ready_i(rdy), .arb_hold_n_i, .arb_grant_pin_n_i(arb_grant_pin_oe_o ? arb_grant_pin_n_o : gnt_n),
        .arb_grant_pin_n_o, .arb_grant_pin_oe_o, .arb_next_request_out_n_o(bus_req_n),
        .arb_next_request_out_oe_o(bus_req_oe),
        .onchip_module_bus_sel_o(), .onchip_module_bus_rd_o(onchip_rd), .onchip_module_bus_wr_o(),
        .onchip_module_bus_addr_o(onchip_adr), .onchip_module_bus_wdata_o(), .onchip_module_bus_rdata_i(16'hc3a5),
        .onchip_module_bus_rdy_i(ocnt >= slow)
    );
    eau_ext_mem u_mem (
        .clk_i, .ale_i(ale_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .dmx_oe_i(dmx_oe), .dmx_i(dmx),
        .sh_oe_i(sh_oe), .sh_i(sh_o), .slow_i(slow), .pol_i(cfg_ready_high_i), .data_o(mdat), .rdy_o(rdy)
    );

    // selects and segment seen in address phase, slow on-chip target
    always @(posedge clk_i) begin
        if (ale_o) begin
            cs_seen <= cs_n_o;
            seg_seen <= segment_addr_o;
        end
        if (onchip_rd)
            oadr_seen <= onchip_adr;
        ocnt <= onchip_rd ? ocnt + {3'h0, ocnt != 4'hf} : 4'h0;
    end

    // ------------------
    // tasks
    // ------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tmo(input logic ok);
        chk(ok, 1, "wait done");
        if (ok !== 1'b1)
            wrap_up;
    endtask
    // one access, held until taken, then wait for the answer
    task automatic acc(input logic wr, input logic [23:0] a, input logic [15:0] wd);
        int n = 0;
        req_write_i = wr;
        req_addr_i = a;
        req_wdata_i = wd;
        req_valid_i = 1;
        while (req_ready_o !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        tmo(req_ready_o === 1'b1);
        @(posedge clk_i);
        #1 req_valid_i = 0;
        lat = 0;
        while (rsp_valid_o !== 1'b1 && lat < 300) begin
            @(negedge clk_i);
            lat++;
        end
        tmo(rsp_valid_o === 1'b1);
        err = rsp_err_o;
        @(posedge clk_i);
        #1;
    endtask
    task automatic grant_wait(input logic lvl);
        int n = 0;
        while (arb_grant_pin_n_o !== lvl && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        tmo(arb_grant_pin_n_o === lvl);
        @(posedge clk_i);
        #1;
    endtask

    // ------------------
    // scenarios
    // ------------------
    initial begin
        repeat (4) @(posedge clk_i);
        #1 rst_i = 0;
        chk(cs_n_o, 5'h1f, "cs_n idle");
        chk(arb_grant_pin_oe_o, 0, "grant oe idle");
        for (int i = 0; i < 5; i++) begin
            d = 16'ha5c3 + 16'h1111 * i[15:0];
            acc(1, adr[i], d);
            acc(0, adr[i], 16'h0);
            chk(rsp_rdata_o, w8[i] ? {8'h00, d[7:0]} : d, "rdata");
            chk(stat_window_o, win[i], "window");
            chk(cs_seen, csx[i], "cs_n");
            chk(seg_seen, adr[i][23:16] & 8'h03, "segment");
        end
        $display("test windows done");
        win_en = 4'h0;
        acc(0, 24'h0a0008, 16'h0);
        chk(stat_window_o, 0, "window off");
        chk(cs_seen, 5'h1e, "cs_n off");
        win_en = 4'hf;
        tcfg = 5'h10;
        slow = 4'h6;
        for (int p = 0; p < 2; p++) begin
            cfg_ready_high_i = p[0];
            acc(0, 24'h001002, 16'h0);
            chk(rsp_rdata_o, 16'ha5c3, "rdata slow");
            chk(lat > 9, 1, "ready stretch");
        end
        $display("test ready done");
        // refusal, on-chip with its own slow ready
        cfg_single_chip_i = 1;
        acc(0, 24'h001002, 16'h0);
        chk(err, 1, "refusal");
        cfg_single_chip_i = 0;
        acc(0, 24'h200010, 16'h0);
        chk(rsp_rdata_o, 16'hc3a5, "onchip");
        chk(oadr_seen, 24'h200010, "onchip addr");
        chk(lat > 9, 1, "onchip ready");
        tcfg = 5'h00;
        $display("test modes done");
        cfg_arb_enable_i = 1;
        arb_hold_n_i = 0;
        grant_wait(0);
        chk(ctrl_oe_o, 0, "ctrl oe");
        chk(owned, 0, "owned in hold");
        chk(arb_grant_pin_oe_o, 1, "grant oe");
        arb_hold_n_i = 1;
        grant_wait(1);
        acc(0, 24'h001002, 16'h0);
        chk(rsp_rdata_o, 16'ha5c3, "after hold");
        // slave asks for the bus, then runs on the grant input
        cfg_arb_slave_i = 1;
        req_write_i = 0;
        req_addr_i = 24'h001002;
        req_valid_i = 1;
        repeat (4) @(posedge clk_i);
        #1;
        chk(bus_req_n, 0, "bus request");
        chk(bus_req_oe, 1, "bus request oe");
        chk(owned, 0, "owned before grant");
        gnt_n = 0;
        acc(0, 24'h001002, 16'h0);
        chk(arb_grant_pin_oe_o, 0, "slave oe");
        chk(owned, 1, "owned on grant");
        chk(rsp_rdata_o, 16'ha5c3, "slave read");
        $display("test arbitration done");
        wrap_up;
    end
endmodule
`default_nettype wire
